/* rtl/ssp_consts.svh */
// Purpose: offsets, reset values and counts of the serial port
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: each register sits in the low bits of one aligned word
// Notes on behaviour
// - Async frame: start, 8/9 bits, 1-2 stops
// - Async bits go LSB first
// - Parity generated on send, checked on receive
// - Ninth wake bit marks address frames
// - IrDA pulses, fixed or programmable width
// - Sync mode: port drives shift clock, bytes
// - Sync mode shifts LSB first, always
// - Async full duplex, sync half duplex
// - Eight-entry FIFO each direction
// - Autobaud measures rate, loads generator, mode
// - Missing stop bit flags framing error
// - Full receive buffer on completion: overrun
// - Fractional divider baud generator
// - Async rate programmable over wide range
// - Sync rate programmable over wide range
// - Loop-back routes transmitter into receiver
// - Requests: tx empty, last bit, rx, errors
// - Requests at autobaud start and end
// - Five separate request outputs
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_OFF_CTRL 8'h00
`define SSP_OFF_BAUD 8'h04
`define SSP_OFF_FDIV 8'h08
`define SSP_OFF_IRW 8'h0c
`define SSP_OFF_TXD 8'h10
`define SSP_OFF_RXD 8'h14
`define SSP_OFF_STAT 8'h18
`define SSP_CTRL_RST 12'h000
`define SSP_BAUD_RST 16'h0000
`define SSP_FDIV_RST 9'h000
`define SSP_IRW_RST 4'h3
`define SSP_OVS_LAST 4'hf
`define SSP_OVS_MID 4'h7
`define SSP_IRDA_FIX 4'h3
`define SSP_STOP_IDX 4'h9
`define SSP_LAST8 4'h7
`define SSP_LAST9 4'h8
`define SSP_SYNC_LAST 3'h7
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`endif

/* rtl/ssp_pkg.sv */
// Purpose: types of the serial port
// Assumes: nothing beyond the constants header
// Notes: field order fixes the register bit positions
package ssp_pkg;
  // Control word, en in bit 0
  typedef struct packed {
    logic ren;
    logic abe;
    logic wake;
    logic irda_prog;
    logic irda;
    logic loop;
    logic stop2;
    logic odd;
    logic par;
    logic nine;
    logic sync;
    logic en;
  } ssp_ctrl_t;
  // Status word, tx level in bits 3:0
  typedef struct packed {
    logic       tbusy;
    logic       ab_busy;
    logic       oe;
    logic       fe;
    logic       pe;
    logic [3:0] rx_cnt;
    logic [3:0] tx_cnt;
  } ssp_stat_t;
  typedef enum logic [1:0] {TS_IDLE = 2'h0, TS_ASYNC = 2'h1, TS_SYNC = 2'h2} ssp_tx_st_t;
  typedef enum logic [1:0] {
    RS_IDLE = 2'h0, RS_START = 2'h1, RS_DATA = 2'h2, RS_STOP = 2'h3
  } ssp_rx_st_t;
endpackage : ssp_pkg

/* rtl/ssp_top.sv */
// Purpose: async/sync serial port with AXI4-Lite registers
// Assumes: single clock aclk, synchronous active-low reset
// Notes: requests are one-cycle pulses to an outside controller
`timescale 1ns/1ns
`include "ssp_consts.svh"
module ssp_top
  import ssp_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int AB_W       = 20
) (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  input  logic        rxd_i,
  output logic        rxd_o,
  output logic        rxd_oe,
  output logic        txd_o,
  output logic        irq_tx,
  output logic        irq_tbuf,
  output logic        irq_rx,
  output logic        irq_err,
  output logic        irq_ab
);
  localparam int AW = $clog2(FIFO_DEPTH);

  logic        rx_s1_q, rx_s2_q;
  logic        awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  ssp_ctrl_t   ctrl_q;
  logic [15:0] brl_q, bcnt_q;
  logic [8:0]  fdv_q, facc_q;
  logic [3:0]  irw_q;
  logic [2:0]  flags_q;
  ssp_tx_st_t  tst_q;
  logic [11:0] tsh_q;
  logic [3:0]  tbit_q, tos_q, tlast_q;
  logic        tsrx_q, sclk_q, txd_q, rxd_o_q, rxd_oe_q;
  ssp_rx_st_t  rst_q;
  logic [3:0]  ros_q, rbit_q;
  logic [8:0]  rsh_q;
  logic        rlow_q, rnine_q, ab_busy_q;
  logic [AB_W-1:0] ab_cnt_q;
  logic        irq_tx_q, irq_tbuf_q, irq_rx_q, irq_err_q, irq_ab_q;
  logic [1:0]  f_push, f_pop;
  logic [8:0]  f_din [2];
  logic [8:0]  f_dout [2];
  logic [AW:0] f_cnt [2];

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
    if (!aresetn)
      {rx_s1_q, rx_s2_q} <= 2'h3;
    else
      {rx_s1_q, rx_s2_q} <= {rxd_i, rx_s1_q};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Both write channels taken together in one cycle
  wire        wr      = awready_q & s_axi_awvalid & s_axi_wvalid;
  wire        rd      = arready_q & s_axi_arvalid;
  wire [31:0] wm      = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd      = s_axi_wdata & wm;
  wire        wa_ctrl = wr & (s_axi_awaddr == `SSP_OFF_CTRL);
  wire        wa_baud = wr & (s_axi_awaddr == `SSP_OFF_BAUD);
  wire        wa_fdiv = wr & (s_axi_awaddr == `SSP_OFF_FDIV);
  wire        wa_irw  = wr & (s_axi_awaddr == `SSP_OFF_IRW);
  wire        wa_txd  = wr & (s_axi_awaddr == `SSP_OFF_TXD);
  wire        wa_stat = wr & (s_axi_awaddr == `SSP_OFF_STAT);
  wire        aw_ok   = wa_ctrl | wa_baud | wa_fdiv | wa_irw | wa_txd | wa_stat
                        | (s_axi_awaddr == `SSP_OFF_RXD);
  wire        ar_rxd  = s_axi_araddr == `SSP_OFF_RXD;
  wire        tf_ne   = f_cnt[0] != '0;
  wire        tf_nf   = f_cnt[0] != (AW+1)'(FIFO_DEPTH);
  wire        rf_ne   = f_cnt[1] != '0;
  wire        rf_nf   = f_cnt[1] != (AW+1)'(FIFO_DEPTH);
  ssp_stat_t  stat, ws;
  assign stat = '{tbusy: tst_q != TS_IDLE, ab_busy: ab_busy_q, oe: flags_q[2],
                  fe: flags_q[1], pe: flags_q[0], rx_cnt: 4'(f_cnt[1]),
                  tx_cnt: 4'(f_cnt[0])};
  assign ws   = ssp_stat_t'(wd[12:0]);
  wire [31:0] rmux =
    (s_axi_araddr == `SSP_OFF_CTRL) ? {20'h0, ctrl_q} :
    (s_axi_araddr == `SSP_OFF_BAUD) ? {16'h0, brl_q} :
    (s_axi_araddr == `SSP_OFF_FDIV) ? {23'h0, fdv_q} :
    (s_axi_araddr == `SSP_OFF_IRW)  ? {28'h0, irw_q} :
    (s_axi_araddr == `SSP_OFF_STAT) ? {19'h0, stat} :
    (ar_rxd & rf_ne)                ? {23'h0, f_dout[1]} : 32'h0;
  wire ar_ok = ar_rxd | (s_axi_araddr == `SSP_OFF_TXD) | (rmux != 32'h0)
               | (s_axi_araddr <= `SSP_OFF_IRW && s_axi_araddr[1:0] == 2'h0)
               | (s_axi_araddr == `SSP_OFF_STAT);

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // Ready pulses one cycle, only while no answer is pending
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SSP_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `SSP_RESP_OKAY;
      rdata_q   <= 32'h0;
    end
    else
    begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr)
        bresp_q <= aw_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      bvalid_q  <= wr | (bvalid_q & ~s_axi_bready);
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd)
      begin
        rdata_q <= rmux;
        rresp_q <= ar_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end
      rvalid_q  <= rd | (rvalid_q & ~s_axi_rready);
    end

  // ----------------------------------------------------------------
  // FIFOs: index 0 transmit, index 1 receive
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_fifo
    logic [8:0]    mem [FIFO_DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0]   n_q;
    // Pointers and level; callers never push full or pop empty
    always_ff @(posedge aclk)
      if (!aresetn)
      begin
        wp_q <= '0;
        rp_q <= '0;
        n_q  <= '0;
      end
      else
      begin
        wp_q <= wp_q + AW'(f_push[i]);
        rp_q <= rp_q + AW'(f_pop[i]);
        n_q  <= n_q + (AW+1)'(f_push[i]) - (AW+1)'(f_pop[i]);
      end
    // Storage, no reset needed
    always_ff @(posedge aclk)
      if (f_push[i])
        mem[wp_q] <= f_din[i];
    assign f_dout[i] = mem[rp_q];
    assign f_cnt[i]  = n_q;
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Fraction 0 bypasses; else rate scales by fdv/512
  wire [9:0] fsum = {1'b0, facc_q} + {1'b0, fdv_q};
  wire       fen  = (fdv_q == `SSP_FDIV_RST) | fsum[9];
  wire       tick = fen & (bcnt_q == 16'h0000);
  always_ff @(posedge aclk)
    if (!aresetn || !ctrl_q.en)
    begin
      bcnt_q <= `SSP_BAUD_RST;
      facc_q <= `SSP_FDIV_RST;
    end
    else
    begin
      facc_q <= fsum[8:0];
      if (fen)
        bcnt_q <= tick ? brl_q : bcnt_q - 16'h0001;
    end

  // ----------------------------------------------------------------
  // Transmitter and sync shifter
  // ----------------------------------------------------------------
  wire       ninth  = ctrl_q.nine | ctrl_q.par | ctrl_q.wake;
  wire       tb8    = ctrl_q.par ? (^f_dout[0][7:0]) ^ ctrl_q.odd : f_dout[0][8];
  wire [11:0] tframe = ninth ? {2'h3, tb8, f_dout[0][7:0], 1'h0}
                             : {3'h7, f_dout[0][7:0], 1'h0};
  wire [3:0] tlast  = `SSP_STOP_IDX + {3'h0, ninth} + {3'h0, ctrl_q.stop2};
  // Sync mode moves one direction only, chosen by ren
  wire       go_async = ctrl_q.en & ~ctrl_q.sync & tf_ne;
  wire       go_stx   = ctrl_q.en & ctrl_q.sync & ~ctrl_q.ren & tf_ne;
  wire       go_srx   = ctrl_q.en & ctrl_q.sync & ctrl_q.ren & rf_nf;
  wire       t_idle   = tst_q == TS_IDLE;
  wire       a_end    = (tst_q == TS_ASYNC) & tick & (tos_q == `SSP_OVS_LAST)
                        & (tbit_q == tlast_q);
  wire       s_rise   = (tst_q == TS_SYNC) & tick & ~sclk_q;
  wire       s_end    = s_rise & (tbit_q[2:0] == `SSP_SYNC_LAST);
  wire       srx_done = s_end & tsrx_q;
  wire       tline    = (tst_q == TS_ASYNC) ? tsh_q[0] : 1'b1;
  wire [3:0] pw       = ctrl_q.irda_prog ? irw_q : `SSP_IRDA_FIX;
  // IrDA: a zero becomes a short low pulse at bit start
  wire       tx_wire  = ctrl_q.irda ? ~(~tline & (tos_q < pw)) : tline;
  assign f_pop[0] = t_idle & (go_async | go_stx);

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      tst_q   <= TS_IDLE;
      tsh_q   <= 12'hfff;
      tbit_q  <= 4'h0;
      tos_q   <= 4'h0;
      tlast_q <= 4'h0;
      tsrx_q  <= 1'b0;
      sclk_q  <= 1'b1;
    end
    else
      unique case (tst_q)
        TS_IDLE:
        begin
          tbit_q <= 4'h0;
          tos_q  <= 4'h0;
          sclk_q <= 1'b1;
          if (go_async)
          begin
            tst_q   <= TS_ASYNC;
            tsh_q   <= tframe;
            tlast_q <= tlast;
          end
          else if (go_stx | go_srx)
          begin
            tst_q  <= TS_SYNC;
            tsh_q  <= {4'hf, f_dout[0][7:0]};
            tsrx_q <= go_srx;
          end
        end
        TS_ASYNC:
          if (tick)
          begin
            tos_q <= tos_q + 4'h1;
            if (tos_q == `SSP_OVS_LAST)
            begin
              tsh_q  <= {1'b1, tsh_q[11:1]};
              tbit_q <= tbit_q + 4'h1;
              if (a_end)
                tst_q <= TS_IDLE;
            end
          end
        TS_SYNC:
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (s_rise)
            begin
              tsh_q[7:0] <= {tsrx_q ? rx_s2_q : 1'b1, tsh_q[7:1]};
              tbit_q     <= tbit_q + 4'h1;
              if (s_end)
                tst_q <= TS_IDLE;
            end
          end
        default: tst_q <= TS_IDLE;
      endcase

  // Pin drivers; loop-back keeps the pin idle
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      txd_q    <= 1'b1;
      rxd_o_q  <= 1'b1;
      rxd_oe_q <= 1'b0;
    end
    else
    begin
      txd_q    <= ctrl_q.sync ? sclk_q : (ctrl_q.loop | tx_wire);
      rxd_o_q  <= (tst_q == TS_SYNC) ? tsh_q[0] | tsrx_q : 1'b1;
      rxd_oe_q <= (tst_q == TS_SYNC) & ~tsrx_q;
    end

  // ----------------------------------------------------------------
  // Async receiver
  // ----------------------------------------------------------------
  wire       rx_in   = ctrl_q.loop ? tx_wire : rx_s2_q;
  wire       samp    = (rst_q != RS_IDLE) & tick & (ros_q == `SSP_OVS_MID);
  wire       rbit    = ctrl_q.irda ? rlow_q & rx_in : rx_in;
  wire       rx_go   = ctrl_q.en & ~ctrl_q.sync & ~ctrl_q.abe & ~ab_busy_q & ~rx_in;
  wire       rx_done = (rst_q == RS_STOP) & samp;
  wire [8:0] rdat    = rnine_q ? rsh_q : {1'b0, rsh_q[8:1]};
  wire       drop    = ctrl_q.wake & ~rdat[8];
  wire       r_store = (rx_done & ~drop) | srx_done;
  wire       pe_ev   = rx_done & ctrl_q.par & ((^rsh_q) != ctrl_q.odd);
  wire       fe_ev   = rx_done & ~rbit;
  wire       oe_ev   = r_store & ~rf_nf;
  assign f_push = {r_store & rf_nf, wa_txd & s_axi_wstrb[0] & tf_nf};
  assign f_din  = '{wd[8:0], srx_done ? {1'b0, rx_s2_q, tsh_q[7:1]} : rdat};
  assign f_pop[1] = rd & ar_rxd & rf_ne;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      rst_q   <= RS_IDLE;
      ros_q   <= 4'h0;
      rbit_q  <= 4'h0;
      rsh_q   <= 9'h000;
      rlow_q  <= 1'b1;
      rnine_q <= 1'b0;
    end
    else
    begin
      // IrDA: any low from bit start up to the mid-bit sample reads as zero
      rlow_q <= (rst_q == RS_IDLE) ? rx_in
              : ((tick & (ros_q == `SSP_OVS_LAST)) | (rlow_q & rx_in));
      if (rst_q != RS_IDLE && tick)
        ros_q <= ros_q + 4'h1;
      unique case (rst_q)
        RS_IDLE:
        begin
          ros_q   <= 4'h0;
          rbit_q  <= 4'h0;
          rnine_q <= ninth;
          if (rx_go)
            rst_q <= RS_START;
        end
        // A start bit gone high by mid-bit was a glitch
        RS_START:
          if (samp)
            rst_q <= rbit ? RS_IDLE : RS_DATA;
        RS_DATA:
          if (samp)
          begin
            rsh_q  <= {rbit, rsh_q[8:1]};
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == (rnine_q ? `SSP_LAST9 : `SSP_LAST8))
              rst_q <= RS_STOP;
          end
        RS_STOP:
          if (samp)
            rst_q <= RS_IDLE;
      endcase
    end

  // ----------------------------------------------------------------
  // Autobaud: times the start bit of a character whose bit 0 is one
  // ----------------------------------------------------------------
  wire        ab_go   = ctrl_q.abe & ctrl_q.en & ~ctrl_q.sync & ~ab_busy_q
                        & (rst_q == RS_IDLE) & ~rx_in;
  wire        ab_done = ab_busy_q & rx_in;
  wire [15:0] ab_rate = 16'(ab_cnt_q >> 4);
  wire [15:0] ab_brl  = (ab_rate == 16'h0000) ? 16'h0000 : ab_rate - 16'h0001;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ab_busy_q <= 1'b0;
      ab_cnt_q  <= '0;
    end
    else
    begin
      ab_busy_q <= ab_go | (ab_busy_q & ~rx_in);
      ab_cnt_q  <= ab_go ? AB_W'(1) : ab_cnt_q + AB_W'(~&ab_cnt_q);
    end

  // ----------------------------------------------------------------
  // Registers; autobaud result wins over a same-cycle write
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ctrl_q <= ssp_ctrl_t'(`SSP_CTRL_RST);
      brl_q  <= `SSP_BAUD_RST;
      fdv_q  <= `SSP_FDIV_RST;
      irw_q  <= `SSP_IRW_RST;
    end
    else if (ab_done)
    begin
      brl_q       <= ab_brl;
      fdv_q       <= `SSP_FDIV_RST;
      ctrl_q.abe  <= 1'b0;
      ctrl_q.nine <= 1'b0;
      ctrl_q.par  <= 1'b0;
      ctrl_q.wake <= 1'b0;
    end
    else
    begin
      if (wa_ctrl)
        ctrl_q <= ssp_ctrl_t'((ctrl_q & ~wm[11:0]) | wd[11:0]);
      if (wa_baud)
        brl_q <= (brl_q & ~wm[15:0]) | wd[15:0];
      if (wa_fdiv)
        fdv_q <= (fdv_q & ~wm[8:0]) | wd[8:0];
      if (wa_irw)
        irw_q <= (irw_q & ~wm[3:0]) | wd[3:0];
    end

  // Sticky errors: write one clears, a new event wins
  always_ff @(posedge aclk)
    if (!aresetn)
      flags_q <= 3'h0;
    else
      flags_q <= (flags_q & ~(wa_stat ? {ws.oe, ws.fe, ws.pe} : 3'h0))
                 | {oe_ev, fe_ev, pe_ev};

  // Five request pulses
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      irq_tx_q   <= 1'b0;
      irq_tbuf_q <= 1'b0;
      irq_rx_q   <= 1'b0;
      irq_err_q  <= 1'b0;
      irq_ab_q   <= 1'b0;
    end
    else
    begin
      irq_tx_q   <= a_end | (s_end & ~tsrx_q);
      irq_tbuf_q <= f_pop[0] & (f_cnt[0] == (AW+1)'(1));
      irq_rx_q   <= f_push[1];
      irq_err_q  <= pe_ev | fe_ev | oe_ev;
      irq_ab_q   <= ab_go | ab_done;
    end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign txd_o         = txd_q;
  assign rxd_o         = rxd_o_q;
  assign rxd_oe        = rxd_oe_q;
  assign irq_tx        = irq_tx_q;
  assign irq_tbuf      = irq_tbuf_q;
  assign irq_rx        = irq_rx_q;
  assign irq_err       = irq_err_q;
  assign irq_ab        = irq_ab_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_idle_high:
    assert property ((t_idle && !ctrl_q.sync) |=> txd_q)
      else $error("line not high while idle");
  chk_start_low:
    assert property ((f_pop[0] && go_async && !ctrl_q.irda && !ctrl_q.loop)
                     |=> ##1 !txd_q)
      else $error("start bit not low");
  chk_lsb_first:
    assert property ((f_pop[0] && go_async) |=> tsh_q[1] == $past(f_dout[0][0]))
      else $error("first data bit not lsb");
  chk_parity_gen:
    assert property ((f_pop[0] && go_async && ctrl_q.par)
                     |=> (^tsh_q[9:1]) == $past(ctrl_q.odd))
      else $error("parity bit wrong");
  chk_frame_err:
    assert property ((rx_done && !rbit) |=> flags_q[1])
      else $error("framing error not flagged");
  chk_overrun:
    assert property ((r_store && !rf_nf && !f_pop[1])
                     |=> flags_q[2] && f_cnt[1] == $past(f_cnt[1]))
      else $error("overrun not flagged or data stored");
  chk_half_dup:
    assert property ((tst_q == TS_SYNC && tsrx_q) |=> !rxd_oe_q)
      else $error("data pin driven during sync receive");
  chk_fifo_bound:
    assert property (f_cnt[0] <= FIFO_DEPTH && f_cnt[1] <= FIFO_DEPTH)
      else $error("fifo level beyond depth");
  chk_ab_load:
    assert property (ab_done |=> brl_q == $past(ab_brl) && !ctrl_q.abe)
      else $error("autobaud result not loaded");
  chk_ab_irq:
    assert property ((ab_go || ab_done) |=> irq_ab_q ##1 !irq_ab_q || ab_done)
      else $error("autobaud request missing");
endmodule : ssp_top

/* tb/ssp_remote.sv */
// Purpose: remote async station on the port's receive pin
// Assumes: bit time of BIT_CYC clocks
// Notes: frame bits given LSB first, start and stops included
`timescale 1ns/1ns
module ssp_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic aclk,
  output logic      line
);
  initial line = 1'b1;
  // Whole frame, one bit per bit time, then back to idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n * BIT_CYC; i++)
    begin
      @(posedge aclk);
      line <= bits[i / BIT_CYC];
    end
    @(posedge aclk);
    line <= 1'b1;
  endtask : send
endmodule : ssp_remote

/* tb/test_async_sync_serial_port.sv */
// Purpose: self-checking bench of the serial port
// Assumes: BAUD 0, so one bit is 16 clocks
// Notes: expected frames queued by the bench model
`timescale 1ns/1ns
`include "ssp_consts.svh"
module test_async_sync_serial_port;
  import ssp_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp;
  logic awr, wr, bv, arr, rv, rxd, rxd_o, rxd_oe, txd, i_tx, i_tb, i_rx, i_err, i_ab;
  int errors = 0, total_checks = 0, n_tx = 0, n_rx = 0, mon_n = 8, seed = 32'hbc22;
  int n_tb = 0, n_err = 0, n_ab = 0;
  logic sm = 0;
  logic [11:0] exp_q[$];
  logic [8:0] rx_q[$];
  logic [11:0] got;
  always #25 aclk = ~aclk;
  ssp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .rxd_i(rxd),
    .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd), .irq_tx(i_tx), .irq_tbuf(i_tb),
    .irq_rx(i_rx), .irq_err(i_err), .irq_ab(i_ab));
  ssp_remote u_rem (.aclk(aclk), .line(rxd));
  // Request pulse counters
  always @(posedge aclk)
  begin
    n_tx <= n_tx + (i_tx === 1'b1);
    n_rx <= n_rx + (i_rx === 1'b1);
    n_tb <= n_tb + (i_tb === 1'b1);
    n_err <= n_err + (i_err === 1'b1);
    n_ab <= n_ab + (i_ab === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // Bounded wait on a design handshake; a hang ends the run
  task automatic wait_edge(input int sel);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (!((sel == 0 && awr === 1'b1) || (sel == 1 && bv === 1'b1) ||
                 (sel == 2 && arr === 1'b1) || (sel == 3 && rv === 1'b1)) && n < 64);
    if (n >= 64)
    begin
      errors++;
      give_verdict();
    end
  endtask : wait_edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    wait_edge(0);
    awv <= 0;
    wv <= 0;
    bready <= 1;
    wait_edge(1);
    bready <= 0;
    check(bresp, er);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    arv <= 1;
    wait_edge(2);
    arv <= 0;
    rready <= 1;
    wait_edge(3);
    rready <= 0;
    d = rdata;
    check(rresp, er);
  endtask : rd_reg
  // Line monitor: start at mid, then data and stop at each mid
  always
  begin
    // Shift clock edges of sync mode are not frames
    do @(negedge txd); while (sm);
    repeat (8) @(posedge aclk);
    check(txd, 1'b0);
    got = '0;
    for (int i = 0; i <= mon_n; i++)
    begin
      repeat (16) @(posedge aclk);
      got[i] = txd;
    end
    check(got, exp_q.size() ? exp_q.pop_front() : 12'hfff);
  end
  // One remote frame: data d, ninth bit p when nb is 9
  task automatic rx_frame(input logic [7:0] d, input logic p, input int nb, input logic st);
    u_rem.send(nb == 9 ? {st, p, d, 1'b0} : {1'b0, st, d, 1'b0}, nb + 2);
  endtask : rx_frame
  initial
  begin
    logic [7:0] b;
    int n;
    logic pv, pd;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd_reg(`SSP_OFF_CTRL, rd, `SSP_RESP_OKAY);
    check(rd, 32'h0);
    rd_reg(`SSP_OFF_IRW, rd, `SSP_RESP_OKAY);
    check(rd, 32'h3);
    wr_reg(8'h1c, 32'h1, `SSP_RESP_SLVERR);
    $display("test reset done");
    // Back-to-back transmit, plain then even parity
    wr_reg(`SSP_OFF_CTRL, 32'h1, `SSP_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 2)
      begin
        repeat (400) @(posedge aclk);
        mon_n = 9;
        wr_reg(`SSP_OFF_CTRL, 32'h9, `SSP_RESP_OKAY);
      end
      b = $random(seed);
      exp_q.push_back(k < 2 ? {3'h1, b} : {2'h1, ^b, b});
      wr_reg(`SSP_OFF_TXD, {24'h0, b}, `SSP_RESP_OKAY);
    end
    repeat (500) @(posedge aclk);
    check(n_tx, 4);
    check(n_tb, 4);
    check(exp_q.size(), 0);
    $display("test transmit done");
    // Parity error then framing error
    rx_frame(8'h5a, 1'b1, 9, 1'b1);
    rd_reg(`SSP_OFF_STAT, rd, `SSP_RESP_OKAY);
    check(rd[10:8], 3'h1);
    wr_reg(`SSP_OFF_CTRL, 32'h1, `SSP_RESP_OKAY);
    wr_reg(`SSP_OFF_STAT, 32'h700, `SSP_RESP_OKAY);
    rx_frame(8'h33, 1'b0, 8, 1'b0);
    rd_reg(`SSP_OFF_STAT, rd, `SSP_RESP_OKAY);
    check(rd[10:8], 3'h2);
    for (int k = 0; k < 2; k++)
      rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
    check(rd[7:0], 8'h33);
    wr_reg(`SSP_OFF_STAT, 32'h700, `SSP_RESP_OKAY);
    $display("test errors done");
    // Nine frames into an eight-entry buffer
    for (int k = 0; k < 9; k++)
    begin
      b = $random(seed);
      if (k < 8)
        rx_q.push_back({1'b0, b});
      rx_frame(b, 1'b0, 8, 1'b1);
    end
    rd_reg(`SSP_OFF_STAT, rd, `SSP_RESP_OKAY);
    check(rd[10:4], 7'h48);
    // Two frames stored earlier plus eight now; pe, fe, oe once each
    check(n_rx, 10);
    check(n_err, 3);
    while (rx_q.size())
    begin
      rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
      check(rd, {23'h0, rx_q.pop_front()});
    end
    rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
    check(rd, 32'h0);
    $display("test overrun done");
    // Wake mode keeps only frames whose ninth bit is set
    wr_reg(`SSP_OFF_CTRL, 32'h201, `SSP_RESP_OKAY);
    rx_frame(8'ha5, 1'b0, 9, 1'b1);
    rx_frame(8'h3c, 1'b1, 9, 1'b1);
    rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
    check(rd, 32'h13c);
    rd_reg(`SSP_OFF_STAT, rd, `SSP_RESP_OKAY);
    check(rd[7:4], 4'h0);
    $display("test wake done");
    // Autobaud: a 16-clock start bit must replace BAUD 5 by 0
    wr_reg(`SSP_OFF_BAUD, 32'h5, `SSP_RESP_OKAY);
    wr_reg(`SSP_OFF_CTRL, 32'h401, `SSP_RESP_OKAY);
    rx_frame(8'h55, 1'b0, 8, 1'b1);
    check(n_ab, 2);
    rd_reg(`SSP_OFF_BAUD, rd, `SSP_RESP_OKAY);
    check(rd, 32'h0);
    rd_reg(`SSP_OFF_CTRL, rd, `SSP_RESP_OKAY);
    check(rd, 32'h1);
    // Rest of the character lands from its first zero data bit
    repeat (40) @(posedge aclk);
    rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
    check(rd, 32'hd5);
    $display("test autobaud done");
    // Loop-back keeps the pin idle and feeds the receiver
    wr_reg(`SSP_OFF_CTRL, 32'h41, `SSP_RESP_OKAY);
    wr_reg(`SSP_OFF_TXD, 32'hc3, `SSP_RESP_OKAY);
    repeat (220) @(posedge aclk);
    check(txd, 1'b1);
    rd_reg(`SSP_OFF_RXD, rd, `SSP_RESP_OKAY);
    check(rd[7:0], 8'hc3);
    $display("test loop-back done");
    // Sync transmit: data taken as it stood before each clock rise
    sm = 1;
    wr_reg(`SSP_OFF_CTRL, 32'h3, `SSP_RESP_OKAY);
    b = $random(seed);
    wr_reg(`SSP_OFF_TXD, {24'h0, b}, `SSP_RESP_OKAY);
    got = '0;
    n = 0;
    pv = 1'b1;
    pd = 1'b1;
    for (int c = 0; c < 100; c++)
    begin
      @(posedge aclk);
      if (txd && !pv && n < 12)
      begin
        got[n] = pd;
        n++;
      end
      pv = txd;
      pd = rxd_o;
    end
    check(got, {4'h0, b});
    check(n, 8);
    check(rxd_oe, 1'b0);
    $display("test sync done");
    give_verdict();
  end
endmodule : test_async_sync_serial_port
